// ### pkg/t2cr_map.svh
// Register offsets, bit positions and reset values of the timer 2 control block
`ifndef T2CR_MAP_SVH
`define T2CR_MAP_SVH

`define T2CR_ADDR_CONTROL 8'hC8
`define T2CR_ADDR_MODE 8'hC9
`define T2CR_ADDR_CAPTURE_LOW 8'hCA
`define T2CR_ADDR_CAPTURE_HIGH 8'hCB
`define T2CR_ADDR_COUNT_LOW 8'hCC
`define T2CR_ADDR_COUNT_HIGH 8'hCD

`define T2CR_BIT_OVERFLOW_FLAG 7
`define T2CR_BIT_EXTERNAL_EDGE_FLAG 6
`define T2CR_BIT_RX_CLOCK_ROUTING 5
`define T2CR_BIT_TX_CLOCK_ROUTING 4
`define T2CR_BIT_EXT_TRIGGER_ENABLE 3
`define T2CR_BIT_RUN_CONTROL 2
`define T2CR_BIT_COUNTER_SELECT 1
`define T2CR_BIT_CAPTURE_RELOAD_SELECT 0
`define T2CR_BIT_DOWN_COUNT_ENABLE 0

`define T2CR_RESET_CONTROL 8'h00
`define T2CR_RESET_MODE 8'h00
`define T2CR_RESET_BYTE 8'h00
`define T2CR_UNMAPPED_READ 8'h00
`define T2CR_COUNT_TOP 16'hFFFF
`define T2CR_COUNT_STEP 16'h0001

`endif

// ### pkg/t2cr_pkg.sv
// Types shared by the timer 2 control block
package t2cr_pkg;
  typedef enum logic [1:0] {
    T2CR_MODE_CAPTURE,
    T2CR_MODE_RELOAD_UP,
    T2CR_MODE_RELOAD_UPDOWN,
    T2CR_MODE_SERIAL_CLOCK
  } t2cr_mode_type;
endpackage : t2cr_pkg

// ### pkg/t2cr_pin_if.sv
// Synchronised trigger pin level and falling-edge pulses between pin stage and timer
interface t2cr_pin_if;
  logic trigger_level;
  logic trigger_fall;
  logic count_fall;
  modport source (output trigger_level, output trigger_fall, output count_fall);
  modport sink (input trigger_level, input trigger_fall, input count_fall);
endinterface : t2cr_pin_if

// ### src/t2cr_pin_sync.sv
// Two-flop synchronisers and falling-edge detectors for the trigger and count pins
module t2cr_pin_sync (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Raw pins
  input wire logic trigger_pin_in,
  input wire logic external_count_input_in,
  // Conditioned pins
  t2cr_pin_if.source pins
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pins idle high, so reset to one to avoid a false edge
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {external_count_input_in, trigger_pin_in};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pins.trigger_level = sync_r[0];
  assign pins.trigger_fall = prev_r[0] & ~sync_r[0];
  assign pins.count_fall = prev_r[1] & ~sync_r[1];
endmodule : t2cr_pin_sync

// ### src/t2cr_timer.sv
// Timer 2 control: run control, capture, auto-reload, flags and serial clock routing
// Summary of operation
// - Overflow sets bit 7; only software clears.
// - No overflow flag while either routing bit set.
// - Trigger-caused capture or reload sets bit 6.
// - External flag requests interrupt; software clears it.
// - Down-count mode: external flag raises no interrupt.
// - Bit 5 routes overflows to receiver clock.
// - Bit 4 routes overflows to transmitter clock.
// - Trigger edges act only if enabled, not routing.
// - Run bit starts and stops counting.
// - Counter select: timer or external falling edges.
// - Capture select plus enable: trigger edge captures.
// - Reload select: reload on overflow and trigger.
// - Routing forces reload, ignores capture select.
// - Control at 0C8H, bit access, resets zero.
// - Capture copies count bytes into capture bytes.
// - Reload loads count from capture pair.
// - Down mode: pin sets direction, underflow reloads FFFF.
// - Interrupt request is OR of both flags; external flag masked in down mode.
`include "t2cr_map.svh"

module t2cr_timer
  import t2cr_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Special-function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_idx_in,
  input wire logic sfr_bit_val_in,
  output logic [7:0] sfr_rdata_out,
  // Pins
  input wire logic trigger_pin_in,
  input wire logic external_count_input_in,
  // Serial port clocking
  input wire logic timer1_overflow_in,
  output logic rx_bit_clock_out,
  output logic tx_bit_clock_out,
  // Interrupt request towards the core
  output logic timer_irq_out
);
  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic down_count_enable_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capture_r;
  logic [7:0] ctl_written;
  logic ctl_wr;
  logic overflow_flag;
  logic external_edge_flag;
  logic rx_clock_routing;
  logic tx_clock_routing;
  logic ext_trigger_enable;
  logic run_control;
  logic counter_select;
  logic capture_reload_select;
  logic clock_routing;
  logic tick;
  logic count_up;
  logic wrap_up;
  logic wrap_down;
  logic wrap;
  logic trigger_event;
  logic do_capture;
  logic trigger_reload;
  t2cr_mode_type mode;
  t2cr_pin_if pins ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  t2cr_pin_sync u_pin_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .trigger_pin_in(trigger_pin_in),
    .external_count_input_in(external_count_input_in),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  assign overflow_flag = control_r[`T2CR_BIT_OVERFLOW_FLAG];
  assign external_edge_flag = control_r[`T2CR_BIT_EXTERNAL_EDGE_FLAG];
  assign rx_clock_routing = control_r[`T2CR_BIT_RX_CLOCK_ROUTING];
  assign tx_clock_routing = control_r[`T2CR_BIT_TX_CLOCK_ROUTING];
  assign ext_trigger_enable = control_r[`T2CR_BIT_EXT_TRIGGER_ENABLE];
  assign run_control = control_r[`T2CR_BIT_RUN_CONTROL];
  assign counter_select = control_r[`T2CR_BIT_COUNTER_SELECT];
  assign capture_reload_select = control_r[`T2CR_BIT_CAPTURE_RELOAD_SELECT];
  assign clock_routing = rx_clock_routing | tx_clock_routing;

  // Routing overrides the capture select
  always_comb begin
    if (clock_routing) begin
      mode = T2CR_MODE_SERIAL_CLOCK;
    end else if (capture_reload_select) begin
      mode = T2CR_MODE_CAPTURE;
    end else if (down_count_enable_r) begin
      mode = T2CR_MODE_RELOAD_UPDOWN;
    end else begin
      mode = T2CR_MODE_RELOAD_UP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count engine
  // Timer function advances every core clock; no prescaler is modelled
  assign tick = run_control & (counter_select ? pins.count_fall : 1'b1);
  assign count_up = (mode != T2CR_MODE_RELOAD_UPDOWN) | pins.trigger_level;
  assign wrap_up = tick & count_up & (count_r == `T2CR_COUNT_TOP);
  assign wrap_down = tick & ~count_up & (count_r == capture_r);
  assign wrap = wrap_up | wrap_down;
  assign trigger_event = pins.trigger_fall & ext_trigger_enable & ~clock_routing;
  assign do_capture = trigger_event & (mode == T2CR_MODE_CAPTURE);
  // In up/down mode the trigger pin is direction, not a reload source
  assign trigger_reload = trigger_event & (mode == T2CR_MODE_RELOAD_UP);

  always_comb begin
    count_nxt = count_r;
    case (mode)
      T2CR_MODE_CAPTURE: begin
        if (tick) begin
          count_nxt = count_r + `T2CR_COUNT_STEP;
        end
      end
      T2CR_MODE_RELOAD_UPDOWN: begin
        if (wrap_down) begin
          count_nxt = `T2CR_COUNT_TOP;
        end else if (wrap_up) begin
          count_nxt = capture_r;
        end else if (tick) begin
          count_nxt = count_up ? count_r + `T2CR_COUNT_STEP : count_r - `T2CR_COUNT_STEP;
        end
      end
      default: begin
        if (wrap_up || trigger_reload) begin
          count_nxt = capture_r;
        end else if (tick) begin
          count_nxt = count_r + `T2CR_COUNT_STEP;
        end
      end
    endcase
  end

  // Software writes to the count win over counting in the same cycle
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      count_r <= {`T2CR_RESET_BYTE, `T2CR_RESET_BYTE};
    end else if (sfr_wr_in && sfr_addr_in == `T2CR_ADDR_COUNT_LOW) begin
      count_r <= {count_nxt[15:8], sfr_wdata_in};
    end else if (sfr_wr_in && sfr_addr_in == `T2CR_ADDR_COUNT_HIGH) begin
      count_r <= {sfr_wdata_in, count_nxt[7:0]};
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      capture_r <= {`T2CR_RESET_BYTE, `T2CR_RESET_BYTE};
    end else if (do_capture) begin
      capture_r <= count_r;
    end else if (sfr_wr_in && sfr_addr_in == `T2CR_ADDR_CAPTURE_LOW) begin
      capture_r[7:0] <= sfr_wdata_in;
    end else if (sfr_wr_in && sfr_addr_in == `T2CR_ADDR_CAPTURE_HIGH) begin
      capture_r[15:8] <= sfr_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, byte and single-bit writes
  always_comb begin
    ctl_written = control_r;
    ctl_wr = 1'b0;
    if (sfr_addr_in == `T2CR_ADDR_CONTROL) begin
      if (sfr_wr_in) begin
        ctl_written = sfr_wdata_in;
        ctl_wr = 1'b1;
      end else if (sfr_bit_wr_in) begin
        ctl_written[sfr_bit_idx_in] = sfr_bit_val_in;
        ctl_wr = 1'b1;
      end
    end
  end

  always_comb begin
    control_nxt = ctl_wr ? ctl_written : control_r;
    if (wrap && !clock_routing) begin
      control_nxt[`T2CR_BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (mode == T2CR_MODE_RELOAD_UPDOWN) begin
      // Seventeenth count bit in up/down mode
      if (wrap) begin
        control_nxt[`T2CR_BIT_EXTERNAL_EDGE_FLAG] = ~control_nxt[`T2CR_BIT_EXTERNAL_EDGE_FLAG];
      end
    end else if (trigger_event) begin
      control_nxt[`T2CR_BIT_EXTERNAL_EDGE_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      control_r <= `T2CR_RESET_CONTROL;
    end else begin
      control_r <= control_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      down_count_enable_r <= 1'b0;
    end else if (sfr_wr_in && sfr_addr_in == `T2CR_ADDR_MODE) begin
      down_count_enable_r <= sfr_wdata_in[`T2CR_BIT_DOWN_COUNT_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the address
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sfr_rdata_out <= `T2CR_UNMAPPED_READ;
    end else if (sfr_addr_in == `T2CR_ADDR_CONTROL) begin
      sfr_rdata_out <= control_r;
    end else if (sfr_addr_in == `T2CR_ADDR_MODE) begin
      sfr_rdata_out <= {7'h00, down_count_enable_r};
    end else if (sfr_addr_in == `T2CR_ADDR_CAPTURE_LOW) begin
      sfr_rdata_out <= capture_r[7:0];
    end else if (sfr_addr_in == `T2CR_ADDR_CAPTURE_HIGH) begin
      sfr_rdata_out <= capture_r[15:8];
    end else if (sfr_addr_in == `T2CR_ADDR_COUNT_LOW) begin
      sfr_rdata_out <= count_r[7:0];
    end else if (sfr_addr_in == `T2CR_ADDR_COUNT_HIGH) begin
      sfr_rdata_out <= count_r[15:8];
    end else begin
      sfr_rdata_out <= `T2CR_UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial bit clocks and interrupt request
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rx_bit_clock_out <= 1'b0;
      tx_bit_clock_out <= 1'b0;
    end else begin
      rx_bit_clock_out <= rx_clock_routing ? wrap_up : timer1_overflow_in;
      tx_bit_clock_out <= tx_clock_routing ? wrap_up : timer1_overflow_in;
    end
  end

  // Flags are never cleared by servicing; only software clears them, bar the bit 6 toggle in up/down mode
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= overflow_flag | (external_edge_flag & ~down_count_enable_r);
    end
  end
endmodule : t2cr_timer

// ### verification/t2cr_timer_checker.sv
// Port-level assertions for the timer 2 control block
module t2cr_timer_checker (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_idx_in,
  input wire logic sfr_bit_val_in,
  input wire logic [7:0] sfr_rdata_out,
  // Serial clocks and interrupt
  input wire logic timer1_overflow_in,
  input wire logic rx_bit_clock_out,
  input wire logic tx_bit_clock_out,
  input wire logic timer_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rx_route_r;
  logic tx_route_r;
  logic ctl_bit_wr;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  // Routing shadow; only software moves these bits
  assign ctl_bit_wr = sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in == 8'hC8;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rx_route_r <= 1'b0;
      tx_route_r <= 1'b0;
    end else if (sfr_wr_in && sfr_addr_in == 8'hC8) begin
      rx_route_r <= sfr_wdata_in[5];
      tx_route_r <= sfr_wdata_in[4];
    end else if (ctl_bit_wr && sfr_bit_idx_in == 3'h5) begin
      rx_route_r <= sfr_bit_val_in;
    end else if (ctl_bit_wr && sfr_bit_idx_in == 3'h4) begin
      tx_route_r <= sfr_bit_val_in;
    end
  end
  ////////////////////////////////////////
  reset_outputs_a: assert property ($rose(reset_n_in) |->
    !timer_irq_out && !rx_bit_clock_out && !tx_bit_clock_out && sfr_rdata_out == 8'h00)
    else $error("outputs not clear after reset");
  unmapped_read_a: assert property ((sfr_addr_in < 8'hC8 || sfr_addr_in > 8'hCD) |=>
    sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
  mode_read_a: assert property (sfr_addr_in == 8'hC9 |=> sfr_rdata_out[7:1] == 7'h00)
    else $error("mode upper bits not zero");
  ctl_readback_a: assert property (sfr_wr_in && sfr_addr_in == 8'hC8 && sfr_wdata_in == 8'h00
    ##1 sfr_addr_in == 8'hC8 && !sfr_wr_in && !sfr_bit_wr_in |=> sfr_rdata_out == 8'h00)
    else $error("control readback wrong");
  rx_timer1_a: assert property (!rx_route_r && timer1_overflow_in |=> rx_bit_clock_out)
    else $error("rx clock missed timer 1 pulse");
  tx_timer1_a: assert property (!tx_route_r && timer1_overflow_in |=> tx_bit_clock_out)
    else $error("tx clock missed timer 1 pulse");
  rx_quiet_a: assert property (!rx_route_r && !timer1_overflow_in |=> !rx_bit_clock_out)
    else $error("rx clock pulse without cause");
  tx_quiet_a: assert property (!tx_route_r && !timer1_overflow_in |=> !tx_bit_clock_out)
    else $error("tx clock pulse without cause");
  irq_clear_a: assert property ($fell(timer_irq_out) |-> $past(sfr_wr_in || sfr_bit_wr_in, 2))
    else $error("irq dropped without software write");
  cover property ($rose(timer_irq_out));
  cover property (rx_route_r && rx_bit_clock_out);
  cover property (tx_route_r && tx_bit_clock_out);
endmodule : t2cr_timer_checker

bind t2cr_timer t2cr_timer_checker i_t2cr_timer_checker (.clock_in, .reset_n_in, .sfr_addr_in,
  .sfr_wdata_in, .sfr_wr_in, .sfr_bit_wr_in, .sfr_bit_idx_in, .sfr_bit_val_in, .sfr_rdata_out,
  .timer1_overflow_in, .rx_bit_clock_out, .tx_bit_clock_out, .timer_irq_out);

// ### verification/t2cr_far_model.sv
// Far side: trigger and count pins, timer 1 overflow source
module t2cr_far_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Pins and timer 1
  output logic trigger_pin_out,
  output logic count_pin_out,
  output logic timer1_overflow_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] t1_count_r = 4'h0;
  // Port pins idle high as if pulled up
  initial begin
    trigger_pin_out = 1'b1;
    count_pin_out = 1'b1;
    timer1_overflow_out = 1'b0;
  end
  // Timer 1 pulse every 9 clocks
  always @(posedge clock_in) begin
    t1_count_r <= (!reset_n_in || t1_count_r == 4'h8) ? 4'h0 : t1_count_r + 4'h1;
    timer1_overflow_out <= reset_n_in && t1_count_r == 4'h8;
  end
  // Levels held 3 clocks so the synchroniser never misses one
  task automatic fall_pin(input bit trig, input int n);
    repeat (n) begin
      @(posedge clock_in);
      if (trig) trigger_pin_out <= 1'b0;
      else count_pin_out <= 1'b0;
      repeat (3) @(posedge clock_in);
      trigger_pin_out <= 1'b1;
      count_pin_out <= 1'b1;
      repeat (3) @(posedge clock_in);
    end
  endtask : fall_pin
  // Direction level for up/down counting
  task automatic set_trigger(input logic v);
    @(posedge clock_in);
    trigger_pin_out <= v;
  endtask : set_trigger
endmodule : t2cr_far_model

// ### verification/tb_t2cr_timer.sv
// Self-checking bench for the timer 2 control block
module tb_t2cr_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic bit_wr = 1'b0;
  logic [2:0] bit_idx = 3'h0;
  logic bit_val = 1'b0;
  logic [7:0] rdata;
  logic trig, cnt, t1_ovf, rx_clk, tx_clk, irq;
  int miscompares = 0;
  int checks = 0;
  int rx_n = 0;
  int tx_n = 0;
  int rx0, tx0;
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    rx_n <= rx_n + int'(rx_clk);
    tx_n <= tx_n + int'(tx_clk);
  end
  t2cr_timer i_t2cr_timer (.clock_in, .reset_n_in, .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_wr_in(wr), .sfr_bit_wr_in(bit_wr), .sfr_bit_idx_in(bit_idx), .sfr_bit_val_in(bit_val),
    .sfr_rdata_out(rdata), .trigger_pin_in(trig), .external_count_input_in(cnt),
    .timer1_overflow_in(t1_ovf), .rx_bit_clock_out(rx_clk), .tx_bit_clock_out(tx_clk), .timer_irq_out(irq));
  t2cr_far_model i_t2cr_far_model (.clock_in, .reset_n_in, .trigger_pin_out(trig), .count_pin_out(cnt),
    .timer1_overflow_out(t1_ovf));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic wr_bit(input logic [2:0] i, input logic v);
    @(posedge clock_in);
    addr <= 8'hC8;
    bit_idx <= i;
    bit_val <= v;
    bit_wr <= 1'b1;
    @(posedge clock_in);
    bit_wr <= 1'b0;
  endtask : wr_bit
  // Read data lags the address by one cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr <= a;
    repeat (2) @(posedge clock_in);
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  initial begin
    #250000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    for (int a = 8'hC8; a <= 8'hCE; a++) rd_chk(8'(a), 8'h00);
    $display("test reset values done");
    wr_reg(8'hCB, 8'hFF);
    wr_reg(8'hCA, 8'hF0);
    wr_reg(8'hCD, 8'hFF);
    wr_reg(8'hCC, 8'hF0);
    wr_bit(3'h2, 1'b1);
    repeat (40) @(posedge clock_in);
    wr_bit(3'h2, 1'b0);
    rd_chk(8'hC8, 8'h80);
    rd_chk(8'hCD, 8'hFF);
    chk(irq, 1'b1);
    wr_bit(3'h7, 1'b0);
    repeat (3) @(posedge clock_in);
    chk(irq, 1'b0);
    repeat (40) @(posedge clock_in);
    rd_chk(8'hC8, 8'h00);
    $display("test overflow reload done");
    wr_reg(8'hC8, 8'h31);
    // Timer 1 pulses already in the output flops must drain first
    repeat (2) @(posedge clock_in);
    rx0 = rx_n;
    tx0 = tx_n;
    repeat (40) @(posedge clock_in);
    chk(16'(rx_n - rx0 + tx_n - tx0), 16'h0000);
    wr_bit(3'h2, 1'b1);
    repeat (40) @(posedge clock_in);
    wr_bit(3'h2, 1'b0);
    chk(16'(rx_n > rx0 && tx_n > tx0), 16'h0001);
    rd_chk(8'hC8, 8'h31);
    rd_chk(8'hCD, 8'hFF);
    wr_reg(8'hC8, 8'h00);
    rd_chk(8'hC8, 8'h00);
    $display("test serial routing done");
    wr_reg(8'hCD, 8'h12);
    wr_reg(8'hCC, 8'h00);
    wr_reg(8'hC8, 8'h05);
    i_t2cr_far_model.fall_pin(1'b1, 1);
    wr_bit(3'h2, 1'b0);
    rd_chk(8'hC8, 8'h01);
    rd_chk(8'hCB, 8'hFF);
    wr_bit(3'h3, 1'b1);
    wr_bit(3'h2, 1'b1);
    i_t2cr_far_model.fall_pin(1'b1, 1);
    wr_bit(3'h2, 1'b0);
    rd_chk(8'hCB, 8'h12);
    rd_chk(8'hC8, 8'h49);
    chk(irq, 1'b1);
    wr_reg(8'hC9, 8'h01);
    repeat (3) @(posedge clock_in);
    chk(irq, 1'b0);
    wr_reg(8'hC9, 8'h00);
    wr_reg(8'hC8, 8'h00);
    $display("test capture done");
    wr_reg(8'hCC, 8'h00);
    wr_reg(8'hC8, 8'h06);
    i_t2cr_far_model.fall_pin(1'b0, 5);
    repeat (4) @(posedge clock_in);
    rd_chk(8'hCC, 8'h05);
    $display("test event counter done");
    wr_reg(8'hC8, 8'h00);
    wr_reg(8'hCB, 8'h34);
    wr_reg(8'hCA, 8'h56);
    wr_reg(8'hCD, 8'h00);
    wr_reg(8'hCC, 8'h00);
    wr_reg(8'hC8, 8'h0C);
    i_t2cr_far_model.fall_pin(1'b1, 1);
    wr_bit(3'h2, 1'b0);
    rd_chk(8'hCD, 8'h34);
    rd_chk(8'hC8, 8'h48);
    $display("test trigger reload done");
    wr_reg(8'hC9, 8'h01);
    i_t2cr_far_model.set_trigger(1'b0);
    wr_reg(8'hCB, 8'h00);
    wr_reg(8'hCA, 8'h10);
    wr_reg(8'hCD, 8'h00);
    wr_reg(8'hCC, 8'h18);
    wr_reg(8'hC8, 8'h04);
    repeat (20) @(posedge clock_in);
    wr_bit(3'h2, 1'b0);
    rd_chk(8'hCD, 8'hFF);
    wr_bit(3'h7, 1'b0);
    repeat (3) @(posedge clock_in);
    chk(irq, 1'b0);
    rd_chk(8'hC8, 8'h40);
    $display("test up down done");
    give_verdict();
  end
endmodule : tb_t2cr_timer
